/* File: shared/scw_pkg.sv */
// Shared constants and types for the speed class write classifier link
package scw_pkg;
	// Clocks: host clock and the link clock it divides down
	localparam int CLK_HZ = 20_000_000;
	localparam int LINK_HALF_CLKS = 1; // Host clocks per link half period
	localparam int LINK_HZ = CLK_HZ / (2 * LINK_HALF_CLKS);
	localparam int PWR_LINK_CYC = 4; // Link periods of power-up reset
	// Command indices
	localparam logic [5:0] CMD_SPC = 6'h14; // Speed class control
	localparam logic [5:0] CMD_STATUS = 6'h0D; // Status read
	localparam logic [5:0] CMD_WR1 = 6'h18; // Single block write
	localparam logic [5:0] CMD_WRN = 6'h19; // Multiple block write
	// Position of the speed_class_control_field in the argument
	localparam int SPC_LSB = 28;
	localparam int SPC_W = 4;
	// Functions of the speed_class_control_field
	typedef enum logic [3:0] {
		SPC_START = 4'h1,
		SPC_DIR = 4'h2,
		SPC_CINF = 4'h3
	} scw_spc_e;
	// Card status bits in a response
	localparam int ST_ERR_BIT = 19;
	localparam int ST_READY_BIT = 8;
	localparam int ST_REC_BIT = 5;
	// Sizes, in bytes and in 512-byte blocks
	localparam int BLOCK_BYTES = 512;
	localparam int FT_MAX_BYTES = 16384;
	localparam int FT_MAX_BLOCKS = FT_MAX_BYTES / BLOCK_BYTES;
	localparam int BMP_SPAN_BYTES = 4 * 1024 * 1024;
	localparam int BMP_SPAN_BLOCKS = BMP_SPAN_BYTES / BLOCK_BYTES;
	// Times in their own units
	localparam int START_BUSY_S = 1;
	localparam int DIR_BUSY_MS = 10;
	localparam int CINF_BUSY_MS = 10;
	localparam int CINF_OP_MS = 250;
	localparam int FTW_AVG_MS = 100;
	localparam int FTW_MAX_MS = 750;
	localparam int FTW_WIN = 8; // Update cycles in the sliding average
	// Same times as link clock counts, rounded down as longest times
	localparam int START_BUSY_CYC = START_BUSY_S * LINK_HZ;
	localparam int DIR_BUSY_CYC = DIR_BUSY_MS * (LINK_HZ / 1000);
	localparam int CINF_BUSY_CYC = CINF_BUSY_MS * (LINK_HZ / 1000);
	localparam int CINF_OP_CYC = CINF_OP_MS * (LINK_HZ / 1000);
	localparam int FTW_AVG_CYC = FTW_AVG_MS * (LINK_HZ / 1000);
	localparam int FTW_MAX_CYC = FTW_MAX_MS * (LINK_HZ / 1000);
	// Class of a write as the card sees it
	typedef enum logic [2:0] {
		K_STREAM = 3'h0,
		K_FAT = 3'h1,
		K_BMP = 3'h2,
		K_DIR = 3'h3,
		K_CINF = 3'h4,
		K_PLAIN = 3'h5,
		K_CTRL = 3'h6
	} scw_kind_e;
	// Host user operations
	typedef enum logic [2:0] {
		OP_START = 3'h0,
		OP_DIR = 3'h1,
		OP_CINF = 3'h2,
		OP_FAT = 3'h3,
		OP_BMP = 3'h4,
		OP_STREAM = 3'h5,
		OP_STATUS = 3'h6,
		OP_DIRW = 3'h7
	} scw_op_e;
endpackage

/* File: shared/scw_link_if.sv */
// Card bus link between host controller and card
`timescale 1ns/1ps
`default_nettype none
interface scw_link_if;
	logic lclk; // Link clock made by the host
	logic pwr_rst; // Card power-up reset
	logic cmd_valid; // Command present for one link period
	logic cmd_wr; // Command is a block write
	logic [5:0] cmd_index; // Command index
	logic [31:0] cmd_arg; // Argument or block address
	logic [15:0] cmd_blocks; // Block count of a write
	logic rsp_tgl; // Toggles once per response
	logic [31:0] rsp_status; // Card status of the last response
	logic busy; // Card busy after a response
	logic scr_cmd20; // Configuration bit 32: control command supported
	modport host(output lclk, output pwr_rst, output cmd_valid, output cmd_wr, output cmd_index,
		output cmd_arg, output cmd_blocks, input rsp_tgl, input rsp_status, input busy, input scr_cmd20);
	modport dev(input lclk, input pwr_rst, input cmd_valid, input cmd_wr, input cmd_index,
		input cmd_arg, input cmd_blocks, output rsp_tgl, output rsp_status, output busy, output scr_cmd20);
endinterface
`default_nettype wire

/* File: rtl/scw_card.sv */
// Card end: follows speed class control commands and classifies host writes
// Functional notes
// - File-table update is FAT, bitmap, directory write
// - Host FAT write aligned, up to 16KB; the host checks only the block count, not the alignment
// - Host bitmap write aligned, 512B to 16KB; the host checks the block count and the 4MB span, not the alignment
// - Directory entry rewritten by single block
// - Track file-table time: average and maximum
// - File-table insertions must not cost performance
// - Continuous info insertions must not cost performance
// - Continuous info: command then single block
// - Continuous info update finishes within 250ms
// - Accept repeated or sequential continuous info addresses
// - Tell single-block writes apart by command
// - Host keeps bitmap in first 4MB
// - Error during busy reported on next response
// - Host may poll status after control command
// - Control command answered, then busy held
// - Busy limit depends on selected function
// - Support shown in configuration bit 32
// - Extended cards must support the command
// - Performance guaranteed only after start recording; perf_ok is held high when EXTENDED_CAP is 0
// - Start recording busy at most 1 second
// - Directory update busy at most 10ms
// - Continuous info busy at most 10ms
// - Directory update ends the current recording
`timescale 1ns/1ps
`default_nettype none
module scw_card #(
	parameter bit EXTENDED_CAP = 1'b1, // Extended-capacity card
	parameter bit CMD20_SUPPORT = 1'b1, // Control command implemented
	parameter int START_BUSY_CYC = scw_pkg::START_BUSY_CYC,
	parameter int DIR_BUSY_CYC = scw_pkg::DIR_BUSY_CYC,
	parameter int CINF_BUSY_CYC = scw_pkg::CINF_BUSY_CYC,
	parameter int CINF_OP_CYC = scw_pkg::CINF_OP_CYC,
	parameter int FTW_AVG_CYC = scw_pkg::FTW_AVG_CYC,
	parameter int FTW_MAX_CYC = scw_pkg::FTW_MAX_CYC,
	parameter logic [31:0] FAT_BASE = 32'h0000_0800, // File table start block
	parameter logic [31:0] FAT_LEN = 32'h0000_0400, // File table length in blocks
	parameter logic [31:0] HEAP_BASE = 32'h0000_4000, // Cluster heap start block
	parameter int CLUSTER_BLOCKS = 64 // Blocks per cluster
) (
	scw_link_if.dev lk,
	input wire logic rst,
	output logic core_req,
	output var scw_pkg::scw_kind_e core_kind,
	output logic [31:0] core_addr,
	output logic [15:0] core_blocks,
	input wire logic core_done,
	input wire logic core_err,
	output logic recording,
	output logic perf_ok,
	output logic ftw_avg_late,
	output logic ftw_max_late,
	output logic cinf_late,
	output logic cinf_order_err
);
	localparam int CL_W = $clog2(CLUSTER_BLOCKS);
	localparam logic [31:0] AVG_LIM = 32'(scw_pkg::FTW_WIN * FTW_AVG_CYC);

	// Parameters the logic cannot serve
	if (EXTENDED_CAP && !CMD20_SUPPORT) begin : g_chk_cap
		$error("Extended-capacity card must implement the control command");
	end
	if (CLUSTER_BLOCKS < 2 || (1 << CL_W) != CLUSTER_BLOCKS) begin : g_chk_cl
		$error("CLUSTER_BLOCKS must be a power of two of at least 2");
	end

	typedef enum logic [0:0] {
		D_IDLE = 1'b0,
		D_BUSY = 1'b1
	} scw_dstate_e;
	typedef enum logic [1:0] {
		P_NONE = 2'h0,
		P_DIR = 2'h1,
		P_CINF = 2'h2
	} scw_pend_e;

	logic rst_meta; // Reset synchroniser, first stage
	logic rst_sync; // Reset in the link domain
	scw_dstate_e state_reg; // Idle or busy
	logic [31:0] tmr_reg; // Busy cycles so far
	logic [31:0] lim_reg; // Busy cycle limit
	scw_pkg::scw_kind_e kind_reg; // Class of the operation keeping us busy
	logic err_pend_reg; // Error waiting for the next response
	logic rec_reg; // Recording in progress
	scw_pend_e pend_reg; // Function tagging the next write
	logic dir_ok_reg; // Directory block known
	logic [31:0] dir_addr_reg; // Directory block address
	logic cinf_ok_reg; // A continuous info block seen this recording
	logic [31:0] cinf_last_reg; // Last continuous info block address
	logic rsp_tgl_reg;
	logic [31:0] rsp_status_reg;
	logic [31:0] ftw_acc_reg; // Busy cycles of the current update cycle
	logic [31:0] win_mem [scw_pkg::FTW_WIN]; // Last update cycle times
	logic [2:0] ptr_reg; // Next window slot to write; the oldest entry once the window is full
	logic [3:0] fill_reg; // Valid window entries
	logic [31:0] sum_reg; // Sum over the window

	// Reset reaches the link domain through two flops
	always_ff @(posedge lk.lclk) begin
		rst_meta <= rst | lk.pwr_rst;
		rst_sync <= rst_meta;
	end

	// Command decode
	wire idle = (state_reg == D_IDLE);
	wire is_cmd = lk.cmd_valid && !lk.cmd_wr && idle;
	wire is_wr = lk.cmd_valid && lk.cmd_wr && idle;
	wire accept = is_cmd || is_wr;
	wire [3:0] fn_w = lk.cmd_arg[scw_pkg::SPC_LSB +: scw_pkg::SPC_W];
	wire is_spc = is_cmd && (lk.cmd_index == scw_pkg::CMD_SPC);
	wire fn_start = (fn_w == scw_pkg::SPC_START);
	wire fn_dir = (fn_w == scw_pkg::SPC_DIR);
	wire fn_cinf = (fn_w == scw_pkg::SPC_CINF);
	wire fn_ok = CMD20_SUPPORT && (fn_start || fn_dir || fn_cinf);
	wire spc_go = is_spc && fn_ok;
	wire go_busy = is_wr || spc_go;
	wire single = (lk.cmd_blocks == 16'h0001);

	// Write classification by pending function, size and location
	wire in_fat = (lk.cmd_arg >= FAT_BASE) && (lk.cmd_arg < FAT_BASE + FAT_LEN);
	wire in_bmp = (lk.cmd_arg >= HEAP_BASE) && (lk.cmd_arg < HEAP_BASE + 32'(scw_pkg::BMP_SPAN_BLOCKS));
	wire dir_hit = single && dir_ok_reg && (lk.cmd_arg == dir_addr_reg);
	scw_pkg::scw_kind_e kind_w;
	assign kind_w = (pend_reg == P_DIR) ? scw_pkg::K_DIR :
		(pend_reg == P_CINF) ? scw_pkg::K_CINF :
		dir_hit ? scw_pkg::K_DIR :
		in_fat ? scw_pkg::K_FAT :
		in_bmp ? scw_pkg::K_BMP :
		rec_reg ? scw_pkg::K_STREAM : scw_pkg::K_PLAIN;
	wire scw_pkg::scw_kind_e kind_x = is_wr ? kind_w : scw_pkg::K_CTRL;

	// Busy limit chosen by the selected function
	wire [31:0] spc_lim = fn_start ? 32'(START_BUSY_CYC) :
		fn_dir ? 32'(DIR_BUSY_CYC) : 32'(CINF_BUSY_CYC);
	wire [31:0] lim_w = is_wr ? 32'hFFFF_FFFF : spc_lim;

	// Busy ends on core completion or at the limit
	wire busy_now = (state_reg == D_BUSY);
	wire at_lim = (tmr_reg >= lim_reg - 32'h1);
	wire busy_end = busy_now && (core_done || at_lim);
	wire timeout = busy_now && !core_done && at_lim;
	wire busy_err = busy_now && (core_err || timeout);
	wire [31:0] tmr_tot = tmr_reg + 32'h1;

	// Status word of a response
	logic [31:0] st_w;
	always_comb begin
		st_w = 32'h0000_0000;
		st_w[scw_pkg::ST_ERR_BIT] = err_pend_reg;
		st_w[scw_pkg::ST_READY_BIT] = 1'b1;
		st_w[scw_pkg::ST_REC_BIT] = rec_reg;
	end

	// Idle and busy sequencing
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			state_reg <= D_IDLE;
			tmr_reg <= 32'h0;
			lim_reg <= 32'h0;
			kind_reg <= scw_pkg::K_PLAIN;
		end else if (accept) begin
			state_reg <= go_busy ? D_BUSY : D_IDLE;
			tmr_reg <= 32'h0;
			lim_reg <= lim_w;
			kind_reg <= kind_x;
		end else if (busy_now) begin
			tmr_reg <= tmr_tot;
			if (busy_end) begin
				state_reg <= D_IDLE;
			end
		end
	end

	// Responses and deferred error; a new error beats the clear
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			rsp_tgl_reg <= 1'b0;
			rsp_status_reg <= 32'h0;
			err_pend_reg <= 1'b0;
		end else begin
			if (accept) begin
				rsp_tgl_reg <= ~rsp_tgl_reg;
				rsp_status_reg <= st_w;
			end
			err_pend_reg <= busy_err || (is_spc && !fn_ok) || (err_pend_reg && !accept);
		end
	end

	// Recording state and pending function
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			rec_reg <= 1'b0;
			pend_reg <= P_NONE;
		end else if (spc_go) begin
			if (fn_start) begin
				rec_reg <= 1'b1;
			end else if (fn_dir) begin
				rec_reg <= 1'b0;
				pend_reg <= P_DIR;
			end else begin
				pend_reg <= P_CINF;
			end
		end else if (is_wr) begin
			pend_reg <= P_NONE;
		end
	end

	// Directory block location
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			dir_ok_reg <= 1'b0;
			dir_addr_reg <= 32'h0;
		end else if (is_wr && pend_reg == P_DIR) begin
			dir_ok_reg <= 1'b1;
			dir_addr_reg <= lk.cmd_arg;
		end
	end

	// Continuous info addresses: repeat, step up, or new cluster when full
	wire last_end = (cinf_last_reg[CL_W-1:0] == {CL_W{1'b1}});
	wire cinf_seq_ok = !cinf_ok_reg || (lk.cmd_arg == cinf_last_reg) ||
		(!last_end && lk.cmd_arg == cinf_last_reg + 32'h1) ||
		(last_end && lk.cmd_arg[CL_W-1:0] == {CL_W{1'b0}});
	wire cinf_wr = is_wr && (kind_w == scw_pkg::K_CINF);
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			cinf_ok_reg <= 1'b0;
			cinf_last_reg <= 32'h0;
			cinf_order_err <= 1'b0;
		end else if (spc_go && fn_start) begin
			cinf_ok_reg <= 1'b0;
		end else if (cinf_wr) begin
			cinf_ok_reg <= 1'b1;
			cinf_last_reg <= lk.cmd_arg;
			cinf_order_err <= cinf_order_err || !cinf_seq_ok;
		end
	end

	// Hand each write and each control command that goes busy to the storage core with its class; status reads raise no request
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			core_req <= 1'b0;
			core_kind <= scw_pkg::K_PLAIN;
			core_addr <= 32'h0;
			core_blocks <= 16'h0;
		end else begin
			core_req <= accept && go_busy;
			if (accept) begin
				core_kind <= kind_x;
				core_addr <= is_wr ? lk.cmd_arg : {28'h0, fn_w};
				core_blocks <= is_wr ? lk.cmd_blocks : 16'h0;
			end
		end
	end

	// File-table write time over a sliding window of update cycles
	wire ft_kind = (kind_reg == scw_pkg::K_FAT) || (kind_reg == scw_pkg::K_BMP) || (kind_reg == scw_pkg::K_DIR);
	wire push = busy_end && (kind_reg == scw_pkg::K_DIR);
	wire [31:0] tot_w = ftw_acc_reg + 32'h1;
	wire [31:0] old_w = (fill_reg == 4'h8) ? win_mem[ptr_reg] : 32'h0;
	wire [31:0] sum_w = sum_reg - old_w + tot_w;
	wire [3:0] fill_w = (fill_reg == 4'h8) ? 4'h8 : fill_reg + 4'h1;
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			ftw_acc_reg <= 32'h0;
			ptr_reg <= 3'h0;
			fill_reg <= 4'h0;
			sum_reg <= 32'h0;
			ftw_avg_late <= 1'b0;
			ftw_max_late <= 1'b0;
		end else if (push) begin
			ftw_acc_reg <= 32'h0;
			ptr_reg <= ptr_reg + 3'h1;
			fill_reg <= fill_w;
			sum_reg <= sum_w;
			ftw_max_late <= ftw_max_late || (tot_w > 32'(FTW_MAX_CYC));
			ftw_avg_late <= ftw_avg_late || (fill_w == 4'h8 && sum_w > AVG_LIM);
		end else if (busy_now && ft_kind) begin
			ftw_acc_reg <= tot_w;
		end
	end

	// Window storage
	always_ff @(posedge lk.lclk) begin
		if (push) begin
			win_mem[ptr_reg] <= tot_w;
		end
	end

	// Continuous info operation time
	always_ff @(posedge lk.lclk) begin
		if (rst_sync) begin
			cinf_late <= 1'b0;
		end else if (busy_end && kind_reg == scw_pkg::K_CINF && tmr_tot > 32'(CINF_OP_CYC)) begin
			cinf_late <= 1'b1;
		end
	end

	// Link and user outputs
	assign lk.rsp_tgl = rsp_tgl_reg;
	assign lk.rsp_status = rsp_status_reg;
	assign lk.busy = busy_now;
	assign lk.scr_cmd20 = CMD20_SUPPORT;
	assign recording = rec_reg;
	assign perf_ok = EXTENDED_CAP ? rec_reg : 1'b1;
endmodule
`default_nettype wire

/* File: rtl/scw_host.sv */
// Host end: makes the link clock and issues speed class operations in order
`timescale 1ns/1ps
`default_nettype none
module scw_host #(
	parameter int LINK_HALF = scw_pkg::LINK_HALF_CLKS, // Host clocks per link half period
	parameter logic [31:0] HEAP_BASE = 32'h0000_4000 // Cluster heap start block
) (
	input wire logic clk,
	input wire logic rst,
	scw_link_if.host lk,
	input wire logic req_valid,
	output logic req_ready,
	input wire scw_pkg::scw_op_e req_op,
	input wire logic [31:0] req_addr,
	input wire logic [15:0] req_blocks,
	output logic done,
	output logic done_err,
	output logic [31:0] done_status,
	output logic card_cmd20
);
	if (LINK_HALF < 1 || LINK_HALF > 256) begin : g_chk
		$error("LINK_HALF must lie in 1..256");
	end

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_ISSUE = 3'h1,
		H_HOLD = 3'h2,
		H_RSP = 3'h3,
		H_SETTLE = 3'h4,
		H_BUSY = 3'h5
	} scw_hstate_e;

	logic [7:0] div_reg; // Link clock divider
	logic lclk_reg; // Link clock
	logic [2:0] pwr_cnt_reg; // Link periods of power-up reset done
	logic pwr_rst_reg;
	scw_hstate_e state_reg;
	logic second_reg; // Single block write follows the control command
	logic [31:0] addr_reg; // Address of that write
	logic [1:0] phase_reg; // 0 free, 1 after file table, 2 after bitmap
	logic cmd_valid_reg;
	logic cmd_wr_reg;
	logic [5:0] cmd_index_reg;
	logic [31:0] cmd_arg_reg;
	logic [15:0] cmd_blocks_reg;
	logic tgl_meta, tgl_sync, tgl_last; // Response toggle crossing
	logic busy_meta, busy_sync; // Busy crossing
	logic scr_meta, scr_sync; // Support bit crossing

	// Link clock divider; commands change on its falling edge
	wire tick = (div_reg == 8'(LINK_HALF - 1));
	wire fall = tick && lclk_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			div_reg <= 8'h0;
			lclk_reg <= 1'b0;
		end else begin
			div_reg <= tick ? 8'h0 : div_reg + 8'h1;
			lclk_reg <= tick ? ~lclk_reg : lclk_reg;
		end
	end

	// Card power-up reset held for a few link periods; the count runs on so the
	// card's two-flop reset has cleared before the first command is offered
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_cnt_reg <= 3'h0;
			pwr_rst_reg <= 1'b1;
		end else if (fall && pwr_cnt_reg != 3'h7) begin
			pwr_cnt_reg <= pwr_cnt_reg + 3'h1;
			pwr_rst_reg <= (pwr_cnt_reg < 3'(scw_pkg::PWR_LINK_CYC - 1));
		end
	end

	// Card outputs cross into the host clock
	always_ff @(posedge clk) begin
		tgl_meta <= lk.rsp_tgl;
		tgl_sync <= tgl_meta;
		busy_meta <= lk.busy;
		busy_sync <= busy_meta;
		scr_meta <= lk.scr_cmd20;
		scr_sync <= scr_meta;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tgl_last <= 1'b0;
		end else begin
			tgl_last <= tgl_sync;
		end
	end
	wire rsp_seen = tgl_sync ^ tgl_last;

	// Order and size checks on a request
	wire [31:0] blk32 = {16'h0, req_blocks};
	wire blk_nz = (req_blocks != 16'h0);
	wire blk_ft = blk_nz && (blk32 <= 32'(scw_pkg::FT_MAX_BLOCKS));
	wire bmp_in = (req_addr >= HEAP_BASE) &&
		(req_addr - HEAP_BASE + blk32 <= 32'(scw_pkg::BMP_SPAN_BLOCKS));
	wire free = (phase_reg == 2'h0);
	logic legal;
	always_comb begin
		legal = 1'b1;
		unique case (req_op)
			scw_pkg::OP_START: legal = free;
			scw_pkg::OP_DIR: legal = (phase_reg != 2'h1);
			scw_pkg::OP_DIRW: legal = (phase_reg != 2'h1);
			scw_pkg::OP_CINF: legal = free;
			scw_pkg::OP_FAT: legal = free && blk_ft;
			scw_pkg::OP_BMP: legal = (phase_reg == 2'h1) && blk_ft && bmp_in;
			scw_pkg::OP_STREAM: legal = free && blk_nz;
			scw_pkg::OP_STATUS: legal = 1'b1;
		endcase
	end
	wire is_spc_op = (req_op == scw_pkg::OP_START) || (req_op == scw_pkg::OP_DIR) || (req_op == scw_pkg::OP_CINF);
	wire [3:0] fn_w = (req_op == scw_pkg::OP_START) ? scw_pkg::SPC_START :
		(req_op == scw_pkg::OP_DIR) ? scw_pkg::SPC_DIR : scw_pkg::SPC_CINF;
	wire one_blk = (req_op == scw_pkg::OP_DIRW) || (req_blocks == 16'h0001);
	assign req_ready = (state_reg == H_IDLE) && (pwr_cnt_reg == 3'h7);
	wire take = req_valid && req_ready;

	// Operation sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= H_IDLE;
			second_reg <= 1'b0;
			addr_reg <= 32'h0;
			phase_reg <= 2'h0;
			cmd_valid_reg <= 1'b0;
			cmd_wr_reg <= 1'b0;
			cmd_index_reg <= 6'h0;
			cmd_arg_reg <= 32'h0;
			cmd_blocks_reg <= 16'h0;
			done <= 1'b0;
			done_err <= 1'b0;
			done_status <= 32'h0;
		end else begin
			done <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (take && !legal) begin
						done <= 1'b1;
						done_err <= 1'b1;
					end else if (take) begin
						done_err <= 1'b0;
						state_reg <= H_ISSUE;
						addr_reg <= req_addr;
						second_reg <= is_spc_op && (req_op != scw_pkg::OP_START);
						cmd_wr_reg <= !is_spc_op && (req_op != scw_pkg::OP_STATUS);
						cmd_index_reg <= is_spc_op ? scw_pkg::CMD_SPC :
							(req_op == scw_pkg::OP_STATUS) ? scw_pkg::CMD_STATUS :
							one_blk ? scw_pkg::CMD_WR1 : scw_pkg::CMD_WRN;
						cmd_arg_reg <= is_spc_op ? {fn_w, 28'h0} : req_addr;
						cmd_blocks_reg <= (req_op == scw_pkg::OP_DIRW) ? 16'h0001 : req_blocks;
						if (req_op == scw_pkg::OP_FAT) begin
							phase_reg <= 2'h1;
						end else if (req_op == scw_pkg::OP_BMP) begin
							phase_reg <= 2'h2;
						end else if (req_op == scw_pkg::OP_DIR || req_op == scw_pkg::OP_DIRW) begin
							phase_reg <= 2'h0;
						end
					end
				end
				H_ISSUE: begin
					if (fall) begin
						cmd_valid_reg <= 1'b1;
						state_reg <= H_HOLD;
					end
				end
				H_HOLD: begin
					if (fall) begin
						cmd_valid_reg <= 1'b0;
						state_reg <= H_RSP;
					end
				end
				H_RSP: begin
					if (rsp_seen) begin
						done_status <= lk.rsp_status;
						state_reg <= H_SETTLE;
					end
				end
				H_SETTLE: state_reg <= H_BUSY;
				H_BUSY: begin
					if (!busy_sync && second_reg) begin
						second_reg <= 1'b0;
						cmd_wr_reg <= 1'b1;
						cmd_index_reg <= scw_pkg::CMD_WR1;
						cmd_arg_reg <= addr_reg;
						cmd_blocks_reg <= 16'h0001;
						state_reg <= H_ISSUE;
					end else if (!busy_sync) begin
						done <= 1'b1;
						state_reg <= H_IDLE;
					end
				end
				default: state_reg <= H_IDLE;
			endcase
		end
	end

	assign lk.lclk = lclk_reg;
	assign lk.pwr_rst = pwr_rst_reg;
	assign lk.cmd_valid = cmd_valid_reg;
	assign lk.cmd_wr = cmd_wr_reg;
	assign lk.cmd_index = cmd_index_reg;
	assign lk.cmd_arg = cmd_arg_reg;
	assign lk.cmd_blocks = cmd_blocks_reg;
	assign card_cmd20 = scr_sync;
endmodule
`default_nettype wire

/* File: testbench/scw_link_asserts.sv */
// Link checker: response, busy and pairing relations
`timescale 1ns/1ps
`default_nettype none
module scw_link_asserts #(
	parameter int START_LIM = 50,
	parameter int DIR_LIM = 20
) (
	input wire logic lclk,
	input wire logic pwr_rst,
	input wire logic cmd_valid,
	input wire logic cmd_wr,
	input wire logic [5:0] cmd_index,
	input wire logic [31:0] cmd_arg,
	input wire logic [15:0] cmd_blocks,
	input wire logic rsp_tgl,
	input wire logic [31:0] rsp_status,
	input wire logic busy,
	input wire logic scr_cmd20
);
	logic [3:0] fn_reg; // Function in service
	logic [15:0] cnt_reg; // Busy cycles so far
	logic pair_reg; // One-block write due
	wire logic take = cmd_valid && !busy; // Command accepted
	wire logic ctl = take && cmd_index == scw_pkg::CMD_SPC; // Control taken
	wire logic [3:0] fld = cmd_arg[31:28]; // Selected function
	// Busy length, function and pairing
	always_ff @(posedge lclk) begin
		if (pwr_rst) begin
			fn_reg <= 4'h0;
			cnt_reg <= 16'h0;
			pair_reg <= 1'b0;
		end else begin
			cnt_reg <= busy ? cnt_reg + 16'h1 : 16'h0;
			if (take) begin
				fn_reg <= ctl ? fld : 4'h0;
				pair_reg <= ctl && (fld == scw_pkg::SPC_DIR || fld == scw_pkg::SPC_CINF);
			end
		end
	end
	default clocking cb @(posedge lclk); endclocking
	default disable iff (pwr_rst);
	scr_bit_a: assert property (scr_cmd20) else $error("support bit low");
	ctl_r1b_a: assert property (ctl && fld != 4'h0 && fld <= 4'h3 |=> busy && rsp_tgl != $past(rsp_tgl))
		else $error("control not answered with busy");
	wr_busy_a: assert property (take && cmd_wr |=> busy && rsp_tgl != $past(rsp_tgl))
		else $error("write not answered");
	no_cmd_tgl_a: assert property (!cmd_valid |=> rsp_tgl == $past(rsp_tgl))
		else $error("response without command");
	ready_bit_a: assert property ($changed(rsp_tgl) |-> rsp_status[scw_pkg::ST_READY_BIT])
		else $error("ready bit low");
	start_busy_a: assert property (busy && fn_reg == scw_pkg::SPC_START |-> cnt_reg <= START_LIM + 2)
		else $error("start busy too long");
	dir_busy_a: assert property (busy && fn_reg inside {4'h2, 4'h3} |-> cnt_reg <= DIR_LIM + 2)
		else $error("update busy too long");
	pair_wr_a: assert property (cmd_valid && pair_reg |-> cmd_wr && cmd_index == scw_pkg::CMD_WR1 && cmd_blocks == 16'h1)
		else $error("update not followed by one block");
	cover property (ctl && fld == scw_pkg::SPC_START);
	cover property (ctl && fld == scw_pkg::SPC_CINF);
	cover property (take && cmd_wr && cmd_blocks == 16'h20);
endmodule
`default_nettype wire

/* File: testbench/speed_class_write_classifier_tb.sv */
// Bench: host and card joined over the link
`timescale 1ns/1ps
`default_nettype none
module speed_class_write_classifier_tb;
	logic clk = 1'b0; // Host clock
	logic rst = 1'b1; // Shared reset
	logic req_valid = 1'b0;
	scw_pkg::scw_op_e req_op = scw_pkg::OP_STATUS;
	logic [31:0] req_addr = 32'h0;
	logic [15:0] req_blocks = 16'h0;
	logic req_ready, done, done_err, card_cmd20;
	logic [31:0] done_status, core_addr;
	logic core_req, recording, perf_ok, ftw_avg_late, ftw_max_late, cinf_late, cinf_order_err;
	scw_pkg::scw_kind_e core_kind;
	logic [15:0] core_blocks;
	logic core_err = 1'b0; // Core error
	logic [7:0] dly = 8'h3; // Core service time, 0 never ends
	logic [7:0] dcnt = 8'h0; // Core countdown
	wire logic core_done = (dcnt == 8'h1);
	int n_errors = 0;
	int n_tests = 0;
	scw_link_if lk();
	scw_host i_scw_host (.clk(clk), .rst(rst), .lk(lk), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_addr(req_addr), .req_blocks(req_blocks), .done(done), .done_err(done_err),
		.done_status(done_status), .card_cmd20(card_cmd20));
	scw_card #(.START_BUSY_CYC(50), .CINF_BUSY_CYC(20), .CINF_OP_CYC(30),
		.FTW_AVG_CYC(10), .FTW_MAX_CYC(40)) i_scw_card (.lk(lk), .rst(rst), .core_req(core_req),
		.core_kind(core_kind), .core_addr(core_addr), .core_blocks(core_blocks), .core_done(core_done),
		.core_err(core_err), .recording(recording), .perf_ok(perf_ok), .ftw_avg_late(ftw_avg_late),
		.ftw_max_late(ftw_max_late), .cinf_late(cinf_late), .cinf_order_err(cinf_order_err));
	scw_link_asserts i_scw_link_asserts (.lclk(lk.lclk), .pwr_rst(lk.pwr_rst),
		.cmd_valid(lk.cmd_valid), .cmd_wr(lk.cmd_wr), .cmd_index(lk.cmd_index), .cmd_arg(lk.cmd_arg),
		.cmd_blocks(lk.cmd_blocks), .rsp_tgl(lk.rsp_tgl), .rsp_status(lk.rsp_status), .busy(lk.busy),
		.scr_cmd20(lk.scr_cmd20));
	initial forever #25 clk = ~clk;
	// Core: ends each operation dly link cycles after it starts
	always @(posedge lk.lclk) begin
		if (core_req === 1'b1) dcnt <= dly;
		else if (dcnt != 8'h0) dcnt <= dcnt - 8'h1;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One host request, waits for done
	task automatic req(input scw_pkg::scw_op_e op, input logic [31:0] a, input logic [15:0] b);
		int i;
		i = 0;
		while (req_ready !== 1'b1 && i < 9000) begin
			@(posedge clk);
			#1;
			i++;
		end
		req_valid = 1'b1;
		req_op = op;
		req_addr = a;
		req_blocks = b;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		while (done !== 1'b1 && i < 9000) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (i >= 9000) begin
			n_errors++;
			end_of_test;
		end
	endtask
	task s_start;
		repeat (40) @(posedge clk);
		#1;
		chk("rec_reset", recording, 0);
		chk("cmd20", card_cmd20, 1);
		req(scw_pkg::OP_DIR, 32'h5000, 16'h1);
		chk("dir_kind", core_kind, scw_pkg::K_DIR);
		req(scw_pkg::OP_START, 32'h0, 16'h0);
		chk("perf", perf_ok, 1);
		chk("ctl_fn", core_addr, scw_pkg::SPC_START);
	endtask
	// File-table cycle with refused sizes and places
	task automatic s_cycle;
		scw_pkg::scw_op_e op[6] = '{scw_pkg::OP_FAT, scw_pkg::OP_FAT, scw_pkg::OP_BMP, scw_pkg::OP_BMP,
			scw_pkg::OP_BMP, scw_pkg::OP_DIRW};
		logic [31:0] a[6] = '{32'h800, 32'h800, 32'h4000, 32'h6000, 32'h5FFF, 32'h5000};
		logic [15:0] b[6] = '{16'h21, 16'h20, 16'h0, 16'h1, 16'h1, 16'h1};
		logic e[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		logic [2:0] k[6] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h2, 3'h3};
		for (int j = 0; j < 6; j++) begin
			req(op[j], a[j], b[j]);
			chk("ft_err", done_err, e[j]);
			if (!e[j]) chk("ft_kind", core_kind, k[j]);
		end
		chk("max_late", ftw_max_late, 0);
		req(scw_pkg::OP_STREAM, 32'h20000, 16'h10);
		chk("stream", core_kind, scw_pkg::K_STREAM);
		chk("blocks", core_blocks, 16'h10);
	endtask
	task s_cinf;
		for (int j = 0; j < 3; j++) begin
			req(scw_pkg::OP_CINF, 32'h6000 + (j / 2), 16'h1);
			chk("ci_kind", core_kind, scw_pkg::K_CINF);
		end
		chk("ci_order", cinf_order_err, 0);
		chk("ci_late", cinf_late, 0);
		req(scw_pkg::OP_CINF, 32'h6005, 16'h1);
		chk("ci_jump", cinf_order_err, 1);
	endtask
	// Deferred error, then a start that runs into its limit
	task s_defer;
		core_err = 1'b1;
		req(scw_pkg::OP_START, 32'h0, 16'h0);
		core_err = 1'b0;
		chk("err_now", done_status[19], 0);
		req(scw_pkg::OP_STATUS, 32'h0, 16'h0);
		chk("err_next", done_status[19], 1);
		chk("rec_bit", done_status[5], 1);
		dly = 8'h0;
		req(scw_pkg::OP_START, 32'h0, 16'h0);
		dly = 8'h3;
		req(scw_pkg::OP_STATUS, 32'h0, 16'h0);
		chk("err_lim", done_status[19], 1);
	endtask
	task s_late;
		dly = 8'h64;
		req(scw_pkg::OP_FAT, 32'h800, 16'h1);
		dly = 8'h3;
		req(scw_pkg::OP_BMP, 32'h4000, 16'h1);
		req(scw_pkg::OP_DIRW, 32'h5000, 16'h1);
		chk("max_late", ftw_max_late, 1);
		for (int j = 0; j < 5; j++) req(scw_pkg::OP_DIRW, 32'h5000, 16'h1);
		chk("avg_late", ftw_avg_late, 1);
		dly = 8'h28;
		req(scw_pkg::OP_CINF, 32'h6002, 16'h1);
		dly = 8'h3;
		chk("ci_late", cinf_late, 1);
	endtask
	task s_dirend;
		req(scw_pkg::OP_DIR, 32'h5000, 16'h1);
		chk("rec_end", recording, 0);
		chk("dir_next", core_kind, scw_pkg::K_DIR);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		s_start();
		s_cycle();
		s_cinf();
		s_defer();
		s_late();
		s_dirend();
		end_of_test();
	end
endmodule
`default_nettype wire
